/* common/dmr_burst_if.sv */
// carrier between the burst sequencer and the order generator
interface dmr_burst_if;
  logic [2:0] start;        // starting column low bits
  logic [2:0] beat;         // beat index 0..7
  logic       is_write;     // write burst
  logic       chop;         // chop-4 burst
  logic       interleaved;  // interleaved type
  logic [2:0] col;          // column for this beat
  logic       live;         // beat driven (read) or accepted (write)
  modport seq (output start, beat, is_write, chop, interleaved, input col, live);
  modport ord (input start, beat, is_write, chop, interleaved, output col, live);
endinterface : dmr_burst_if

/* common/dmr_consts.svh */
// constants for the mode register and burst order block
`ifndef DMR_CONSTS_SVH
`define DMR_CONSTS_SVH
// register byte offsets on the AHB-Lite slave
`define DMR_OFF_CTRL      8'h00
`define DMR_OFF_STATUS    8'h04
`define DMR_OFF_BEAT      8'h08
`define DMR_OFF_MR0       8'h10
`define DMR_OFF_MR3       8'h1C
// control bits
`define DMR_CTRL_BURST_EN 0
`define DMR_CTRL_RESET    32'h0000_0000
// mode register width and MR0 field positions
`define DMR_MR_W          15
`define DMR_MR0_BL_LO     0
`define DMR_MR0_BT        3
`define DMR_MR0_DLLRST    8
`define DMR_RW_OTF_A      12
// burst length codes in MR0 A1..A0
`define DMR_BL_FIX8       2'h0
`define DMR_BL_OTF        2'h1
`define DMR_BL_FIX4       2'h2
// last beat index of a burst
`define DMR_LAST_BEAT     3'h7
`endif

/* common/dmr_pkg.sv */
// types shared by the mode register and burst order block
package dmr_pkg;
  // link state as seen by the memory, gray along reset -> wait -> live
  typedef enum logic [1:0] {
    DMR_ST_RESET = 2'h0,
    DMR_ST_WAIT  = 2'h1,
    DMR_ST_LIVE  = 2'h3
  } dmr_state_t;
  typedef logic [14:0] dmr_mr_t;  // one mode register image
endpackage : dmr_pkg

/* hw/dmr_burst_order.sv */
// column order generator for one burst beat
module dmr_burst_order (
  dmr_burst_if.ord bus
);
  logic [1:0] low_sum;  // rotated low bits within a group of four

  // column and liveness of the current beat
  always_comb begin
    low_sum = 2'(bus.start[1:0] + bus.beat[1:0]);
    bus.live = 1'b1;
    if (bus.is_write) begin
      // writes ignore start low bits
      if (bus.chop) begin
        bus.col  = {bus.start[2], bus.beat[1:0]};  // [RULE21]
        bus.live = ~bus.beat[2];                   // [RULE21]
      end else begin
        bus.col = bus.beat;                        // [RULE20]
      end
    end else begin
      if (bus.interleaved) begin
        bus.col = bus.start ^ bus.beat;            // [RULE20]
      end else begin
        bus.col = {bus.start[2] ^ bus.beat[2], low_sum};  // [RULE19]
      end
      if (bus.chop) begin
        bus.live = ~bus.beat[2];                   // [RULE21]
      end
    end
  end
endmodule : dmr_burst_order

/* hw/dmr_top.sv */
// memory-side init tracking, mode registers and burst order, with AHB-Lite access
// Function
// [RULE1] termination off in reset until CKE high
// [RULE2] controller holds ODT static during init
// [RULE3] controller waits tXPR before first MRS
// [RULE4] mode registers loaded MR2, MR3, MR1, MR0
// [RULE5] init enables DLL, then requests DLL reset
// [RULE6] long ZQ calibration, then wait DLL/ZQ
// [RULE7] only NOP or deselect between init commands
// [RULE8] stable-power reset: hold, CKE low, redo
// [RULE9] every mode register written before use
// [RULE10] each MRS gives all fields valid values
// [RULE11] MRS and DLL reset keep array intact
// [RULE12] MRS commands spaced by tMRD
// [RULE13] wait tMOD before non-MRS commands
// [RULE14] MRS only while idle in operation
// [RULE15] ODT low around MRS when termination used
// [RULE16] MR0 selected by BA zero, reserved zero
// [RULE17] write recovery at least rounded tWR
// [RULE18] burst length from A1..A0, A12 on-the-fly
// [RULE19] sequential reads rotate within groups of four
// [RULE20] A3 picks type; interleaved XOR; writes ascend
// [RULE21] chop reads tristate tail; chop writes A2
// [RULE22] controller keeps CKE high through init
// [RULE23] DLL reset bit clears itself
`include "dmr_consts.svh"
module dmr_top (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // memory command pins, asynchronous to mclk
  input  wire logic        mem_ck,
  input  wire logic        mem_rst_n,
  input  wire logic        mem_cke,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_ras_n,
  input  wire logic        mem_cas_n,
  input  wire logic        mem_we_n,
  input  wire logic        mem_odt,
  input  wire logic [2:0]  mem_ba,
  input  wire logic [14:0] mem_addr,
  // termination and beat outputs
  output logic             odt_term_on,
  output logic [2:0]       beat_col,
  output logic             beat_live,
  output logic             beat_valid,
  output logic             beat_wr
);
  localparam int PW = 26;  // synchronised pin bundle width

  logic [PW-1:0]       sync1_r;      // first stage, read only by sync2
  logic [PW-1:0]       sync2_r;      // second stage
  logic                ck_d_r;       // delayed clock for edge find
  logic                ck_s, rst_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s;
  logic [2:0]          ba_s;
  logic [14:0]         addr_s;
  logic                ck_rise;      // rising link clock edge
  logic                cmd_mrs;      // mode register set seen
  logic                cmd_rw;       // read or write seen

  dmr_pkg::dmr_state_t st_r, st_nxt;
  dmr_pkg::dmr_mr_t    mr_r [4];     // mode register images
  dmr_pkg::dmr_mr_t    mr_nxt [4];
  logic [7:0]          dll_cnt_r, dll_cnt_nxt;  // DLL resets done
  logic                odt_r, odt_nxt;
  logic                ctrl_en_r, ctrl_en_nxt;  // burst sequencer enable
  logic                busy_r, busy_nxt;
  logic [2:0]          idx_r, idx_nxt;
  logic [2:0]          start_r, start_nxt;
  logic                wr_r, wr_nxt, chop_r, chop_nxt, il_r, il_nxt;
  logic                go;           // accept a read or write burst
  logic [2:0]          col_r, idx_q_r;
  logic                live_r, valid_r, bwr_r;
  logic                ap_wr_r, ap_wr_nxt, ap_rd;  // AHB address phase
  logic [7:0]          ap_addr_r, ap_addr_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [1:0]          bl_mode;

  dmr_burst_if bif ();

  // pin synchroniser, two stages then a delay tap for the clock
  always_ff @(posedge mclk) begin
    sync1_r <= {mem_ck, mem_rst_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n,
                mem_we_n, mem_odt, mem_ba, mem_addr};
    sync2_r <= sync1_r;
    ck_d_r  <= sync2_r[PW-1];
  end

  assign {ck_s, rst_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, ba_s, addr_s} = sync2_r;
  assign ck_rise = ck_s & ~ck_d_r;
  assign cmd_mrs = ck_rise & rst_s & cke_s & ~cs_s & ~ras_s & ~cas_s & ~we_s;
  assign cmd_rw  = ck_rise & rst_s & cke_s & ~cs_s & ras_s & ~cas_s;
  assign bl_mode = mr_r[0][`DMR_MR0_BL_LO +: 2];

  // link state and termination gating
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dmr_pkg::DMR_ST_RESET: if (rst_s) st_nxt = dmr_pkg::DMR_ST_WAIT;
      dmr_pkg::DMR_ST_WAIT:  if (ck_rise && cke_s) st_nxt = dmr_pkg::DMR_ST_LIVE;  // [RULE1]
      dmr_pkg::DMR_ST_LIVE:  st_nxt = st_r;
      default:               st_nxt = dmr_pkg::DMR_ST_RESET;  // illegal code
    endcase
    if (!rst_s) begin
      st_nxt = dmr_pkg::DMR_ST_RESET;
    end
    odt_nxt = (st_nxt == dmr_pkg::DMR_ST_LIVE) && odt_s;  // [RULE1]
  end

  // mode register writes and DLL reset self-clear
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mr_nxt[i] = mr_r[i];
    end
    dll_cnt_nxt = dll_cnt_r;
    if (mr_r[0][`DMR_MR0_DLLRST]) begin
      mr_nxt[0][`DMR_MR0_DLLRST] = 1'b0;  // [RULE23]
      dll_cnt_nxt = 8'(dll_cnt_r + 8'h01);
    end
    // only the image changes, storage contents are untouched
    if (cmd_mrs && !ba_s[2] && st_r == dmr_pkg::DMR_ST_LIVE) begin
      mr_nxt[ba_s[1:0]] = addr_s;  // [RULE11]
    end
  end

  // burst sequencer
  assign go = cmd_rw && ctrl_en_r && !busy_r && st_r == dmr_pkg::DMR_ST_LIVE;
  always_comb begin
    busy_nxt  = busy_r;
    idx_nxt   = idx_r;
    start_nxt = start_r;
    wr_nxt    = wr_r;
    chop_nxt  = chop_r;
    il_nxt    = il_r;
    if (go) begin
      busy_nxt  = 1'b1;
      idx_nxt   = 3'h0;
      start_nxt = addr_s[2:0];
      wr_nxt    = ~we_s;
      il_nxt    = mr_r[0][`DMR_MR0_BT];  // [RULE20]
      chop_nxt  = (bl_mode == `DMR_BL_FIX4) ||
                  (bl_mode == `DMR_BL_OTF && !addr_s[`DMR_RW_OTF_A]);  // [RULE18]
    end else if (busy_r) begin
      idx_nxt = 3'(idx_r + 3'h1);
      if (idx_r == `DMR_LAST_BEAT) begin
        busy_nxt = 1'b0;
      end
    end
  end

  assign bif.start       = start_r;
  assign bif.beat        = idx_r;
  assign bif.is_write    = wr_r;
  assign bif.chop        = chop_r;
  assign bif.interleaved = il_r;

  dmr_burst_order u_order (
    .bus (bif.ord)
  );

  // AHB-Lite address phase capture and read data
  always_comb begin
    ap_rd       = hsel && hready && htrans[1] && !hwrite;
    ap_wr_nxt   = hsel && hready && htrans[1] && hwrite;
    ap_addr_nxt = ap_wr_nxt ? haddr[7:0] : ap_addr_r;
    ctrl_en_nxt = ctrl_en_r;
    if (ap_wr_r && ap_addr_r == `DMR_OFF_CTRL) begin
      ctrl_en_nxt = hwdata[`DMR_CTRL_BURST_EN];
    end
    rdata_nxt = rdata_r;
    if (ap_rd) begin
      rdata_nxt = 32'h0000_0000;  // unmapped reads zero
      if (haddr[7:0] == `DMR_OFF_CTRL) begin
        rdata_nxt = {31'h0000_0000, ctrl_en_r};
      end else if (haddr[7:0] == `DMR_OFF_STATUS) begin
        rdata_nxt = {16'h0000, dll_cnt_r, 4'h0, odt_r, busy_r,
                     st_r == dmr_pkg::DMR_ST_LIVE, st_r == dmr_pkg::DMR_ST_RESET};
      end else if (haddr[7:0] == `DMR_OFF_BEAT) begin
        rdata_nxt = {23'h00_0000, live_r, valid_r, bwr_r, col_r, idx_q_r};
      end else if (haddr[7:0] >= `DMR_OFF_MR0 && haddr[7:0] <= `DMR_OFF_MR3) begin
        rdata_nxt = {17'h0_0000, mr_r[haddr[3:2]]};
      end
    end
  end

  // register all state but the pin synchroniser
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_r      <= dmr_pkg::DMR_ST_RESET;
      for (int i = 0; i < 4; i++) begin
        mr_r[i] <= 15'h0000;
      end
      dll_cnt_r <= 8'h00;
      odt_r     <= 1'b0;
      ctrl_en_r <= 1'b0;
      busy_r    <= 1'b0;
      idx_r     <= 3'h0;
      start_r   <= 3'h0;
      wr_r      <= 1'b0;
      chop_r    <= 1'b0;
      il_r      <= 1'b0;
      col_r     <= 3'h0;
      idx_q_r   <= 3'h0;
      live_r    <= 1'b0;
      valid_r   <= 1'b0;
      bwr_r     <= 1'b0;
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      st_r      <= st_nxt;
      mr_r      <= mr_nxt;
      dll_cnt_r <= dll_cnt_nxt;
      odt_r     <= odt_nxt;
      ctrl_en_r <= ctrl_en_nxt;
      busy_r    <= busy_nxt;
      idx_r     <= idx_nxt;
      start_r   <= start_nxt;
      wr_r      <= wr_nxt;
      chop_r    <= chop_nxt;
      il_r      <= il_nxt;
      col_r     <= bif.col;
      idx_q_r   <= idx_r;
      live_r    <= busy_r & bif.live;
      valid_r   <= busy_r;
      bwr_r     <= busy_r & wr_r;
      ap_wr_r   <= ap_wr_nxt;
      ap_addr_r <= ap_addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = rdata_r;
  assign odt_term_on = odt_r;
  assign beat_col    = col_r;
  assign beat_live   = live_r;
  assign beat_valid  = valid_r;
  assign beat_wr     = bwr_r;

  // checks
  sequence s_burst_go;
    go;
  endsequence
  sequence s_eight_beats;
    ##2 valid_r [*8];  // first beat stands two cycles after the take
  endsequence

  a_odt_reset_off: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE1]
    (st_r != dmr_pkg::DMR_ST_LIVE) |-> !odt_term_on) else $error("termination on before cke");
  a_dll_self_clear: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE23]
    mr_r[0][`DMR_MR0_DLLRST] |=> !mr_r[0][`DMR_MR0_DLLRST] && dll_cnt_r == 8'($past(dll_cnt_r) + 8'h01))
    else $error("dll reset bit did not clear");
  a_mrs_stores_all: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE11]
    (cmd_mrs && !ba_s[2] && st_r == dmr_pkg::DMR_ST_LIVE && !(ba_s[1:0] == 2'h0 && mr_r[0][8]))
    |=> mr_r[$past(ba_s[1:0])] == $past(addr_s)) else $error("mode register not stored");
  a_burst_eight: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE18]
    s_burst_go |-> s_eight_beats) else $error("burst not eight beats");
  a_chop_tail_off: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE21]
    (valid_r && $past(chop_r) && idx_q_r[2]) |-> !beat_live) else $error("chop tail active");
  a_interleave_xor: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE20]
    (valid_r && !bwr_r && $past(il_r)) |-> beat_col == ($past(start_r) ^ idx_q_r))
    else $error("interleaved order wrong");
  a_seq_rotate: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE19]
    (valid_r && !$past(wr_r) && !$past(il_r)) |->
    beat_col[1:0] == 2'($past(start_r[1:0]) + idx_q_r[1:0])) else $error("sequential order wrong");
  a_write_ascend: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE20]
    (valid_r && bwr_r && !$past(chop_r)) |-> beat_col == idx_q_r) else $error("write order wrong");
  a_chop_type_pick: assert property (@(posedge mclk) disable iff (!reset_n)  // [RULE18]
    (go && bl_mode == `DMR_BL_FIX4) |=> chop_r) else $error("fixed chop not taken");
endmodule : dmr_top

/* tb/dmr_ctl_model.sv */
// controller model driving the memory command pins
module dmr_ctl_model #(
  parameter logic [14:0] MR1_VAL = 15'h0002,  // dll on, no termination
  parameter logic [14:0] MR2_VAL = 15'h0018,
  parameter logic [14:0] MR3_VAL = 15'h0004,
  parameter int          GAP_CK  = 6,         // deselect slots after a command
  parameter int          DLLK_CK = 20         // stand-in for dll lock and zq init
) (
  input  wire logic  mclk,
  output logic       mem_ck,
  output logic       mem_rst_n,
  output logic       mem_cke,
  output logic       mem_cs_n,
  output logic       mem_ras_n,
  output logic       mem_cas_n,
  output logic       mem_we_n,
  output logic       mem_odt,
  output logic [2:0] mem_ba,
  output logic [14:0] mem_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running link clock, 400 ns
  initial begin
    mem_ck = 1'b0;
    forever #200 mem_ck = ~mem_ck;
  end
  // pins idle at time zero
  initial begin
    {mem_rst_n, mem_cke, mem_odt} = 3'h0;
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = 4'hF;
    mem_ba = 3'h0;
    mem_addr = 15'h0000;
  end
  // change pins in a ck low phase, just after an mclk edge
  task automatic slot();
    @(negedge mem_ck);
    @(posedge mclk);
  endtask : slot
  // reset, clock enable and odt levels
  task automatic pins(input logic rst, input logic en, input logic term);
    slot();
    mem_rst_n <= rst;
    mem_cke <= en;
    mem_odt <= term;
  endtask : pins
  // one command for one ck cycle, then deselect gaps
  task automatic cmd(input logic [2:0] rcw, input logic [2:0] bank, input logic [14:0] a);
    slot();
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= {1'b0, rcw};
    mem_ba <= bank;
    mem_addr <= a;
    slot();
    mem_cs_n <= 1'b1;
    mem_ba <= ~bank;  // stale lines not held
    mem_addr <= ~a;
    repeat (GAP_CK) @(negedge mem_ck);
  endtask : cmd
  // full init after cke high
  task automatic init(input logic [14:0] mr0);
    repeat (6) @(negedge mem_ck);
    // mr2, mr3, mr1, then mr0 with dll reset, then long zq calibration
    cmd(3'h0, 3'h2, MR2_VAL);
    cmd(3'h0, 3'h3, MR3_VAL);
    cmd(3'h0, 3'h1, MR1_VAL);
    cmd(3'h0, 3'h0, mr0 | 15'h0100);
    cmd(3'h6, 3'h0, 15'h0400);
    repeat (DLLK_CK) @(negedge mem_ck);
  endtask : init
endmodule : dmr_ctl_model

/* tb/testbench.sv */
// self-checking bench for mode registers and burst order
`include "dmr_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [14:0] MR0_V = 15'h0A00;  // write recovery field set
  logic        mclk, reset_n, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        hreadyout, hresp, odt_term_on, beat_live, beat_valid, beat_wr;
  logic [2:0]  beat_col, mem_ba;
  logic        mem_ck, mem_rst_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_odt;
  logic [14:0] mem_addr;
  int          fail_count, check_count;
  dmr_top u_dmr_top (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_ck, .mem_rst_n, .mem_cke, .mem_cs_n,
    .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_odt, .mem_ba, .mem_addr, .odt_term_on, .beat_col,
    .beat_live, .beat_valid, .beat_wr);
  dmr_ctl_model u_dmr_ctl_model (.mclk, .mem_ck, .mem_rst_n, .mem_cke, .mem_cs_n, .mem_ras_n,
    .mem_cas_n, .mem_we_n, .mem_odt, .mem_ba, .mem_addr);
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // wait for an edge with hready high; only the watchdog ends a hang
  task automatic rdy();
    do begin
      @(posedge mclk);
    end while (hreadyout !== 1'b1);
  endtask : rdy
  // one single-word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask : ahb
  // termination across memory reset and cke
  task automatic t_term();
    logic [31:0] r;
    u_dmr_ctl_model.pins(1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge mclk);  // well over 100 ns held
    chk(32'(odt_term_on), 32'h0);
    ahb(1'b0, `DMR_OFF_STATUS, 32'h0, r);
    chk(32'(r[1:0]), 32'h1);
    u_dmr_ctl_model.pins(1'b1, 1'b0, 1'b1);
    repeat (30) @(posedge mclk);
    chk(32'(odt_term_on), 32'h0);
    u_dmr_ctl_model.pins(1'b1, 1'b0, 1'b0);
    u_dmr_ctl_model.pins(1'b1, 1'b1, 1'b0);
    $display("term test done");
  endtask : t_term
  // init sequence, images, dll reset count, odt follow
  task automatic t_init(input logic [7:0] cnt);
    logic [31:0] r;
    logic [14:0] mr [4];
    mr = '{MR0_V, 15'h0002, 15'h0018, 15'h0004};
    u_dmr_ctl_model.init(MR0_V);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, `DMR_OFF_MR0 + 8'(4 * i), 32'h0, r);
      chk(r, 32'(mr[i]));
    end
    ahb(1'b1, `DMR_OFF_STATUS, 32'hFFFF_FFFF, r);
    ahb(1'b0, `DMR_OFF_STATUS, 32'h0, r);
    chk(r, {16'h0, cnt, 8'h02});
    ahb(1'b0, 8'hFC, 32'h0, r);
    chk(r, 32'h0);  // unmapped
    u_dmr_ctl_model.pins(1'b1, 1'b1, 1'b1);
    repeat (30) @(posedge mclk);
    chk(32'(odt_term_on), 32'h1);
    ahb(1'b0, `DMR_OFF_STATUS, 32'h0, r);
    chk(r, {16'h0, cnt, 8'h0A});
    u_dmr_ctl_model.pins(1'b1, 1'b1, 1'b0);
    repeat (30) @(posedge mclk);
    chk(32'(odt_term_on), 32'h0);
    $display("init test done");
  endtask : t_init
  // judge the eight beats of one burst
  task automatic beats(input logic [2:0] s, input logic wr, input logic bt, input logic chop);
    logic [2:0] idx, col;
    logic       live;
    rdy();
    for (int n = 0; n < 100 && beat_valid !== 1'b1; n++) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      idx = 3'(i);
      live = !chop || i < 4;
      if (wr) col = chop ? {s[2], idx[1:0]} : idx;
      else if (bt) col = s ^ idx;
      else col = {s[2] ^ idx[2], s[1:0] + idx[1:0]};
      chk(32'({beat_valid, beat_wr, beat_live}), 32'({1'b1, wr, live}));
      if (live) chk(32'(beat_col), 32'(col));
      @(posedge mclk);
    end
  endtask : beats
  // every length mode, type and direction from every start column
  task automatic t_burst();
    logic [31:0] r;
    logic [14:0] mr0;
    logic [3:0]  k;
    ahb(1'b1, `DMR_OFF_CTRL, 32'h1, r);
    ahb(1'b0, `DMR_OFF_CTRL, 32'h0, r);
    chk(r, 32'h1);  // burst enable readback
    for (int c = 0; c < 16; c++) begin
      k = 4'(c);
      mr0 = MR0_V;
      mr0[1:0] = k[1:0] == 2'h0 ? `DMR_BL_FIX8 : k[1:0] == 2'h1 ? `DMR_BL_FIX4 : `DMR_BL_OTF;
      mr0[`DMR_MR0_BT] = k[2];
      u_dmr_ctl_model.cmd(3'h0, 3'h0, mr0);
      for (int s = 0; s < 8; s++) begin
        fork
          u_dmr_ctl_model.cmd(k[3] ? 3'h4 : 3'h5, 3'h0, {2'h0, k[1:0] == 2'h3, 9'h0, 3'(s)});
          beats(3'(s), k[3], k[2], k[1:0] == 2'h1 || k[1:0] == 2'h2);
        join
      end
    end
    $display("burst test done");
  endtask : t_burst
  // counts and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // watchdog against a hang
  initial begin
    #2_000_000;
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    {reset_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    ahb(1'b0, `DMR_OFF_MR0, 32'h0, r);
    chk(r, 32'h0);
    t_term();
    t_init(8'h01);
    t_burst();
    t_term();
    t_init(8'h02);
    final_report();
  end
endmodule : testbench
